// ===== cafs_pkg.sv
package cafs_pkg;
    localparam int NUM_FILT = 16;
    localparam int NUM_MASK = 3;

    // register byte offsets
    localparam logic [7:0] OFS_BUFPNT0   = 8'h00;
    localparam logic [7:0] OFS_MSKSEL0   = 8'h10;
    localparam logic [7:0] OFS_MSKSEL1   = 8'h14;
    localparam logic [7:0] OFS_FEN       = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1c;
    localparam logic [7:0] OFS_MASK_BASE = 8'h20;
    localparam logic [7:0] OFS_MASK_END  = 8'h38;
    localparam logic [7:0] OFS_FILT_BASE = 8'h40;
    localparam logic [7:0] OFS_FILT_END  = 8'hc0;
    localparam int         ID_STRIDE_SH  = 3;
    localparam int         EID_WORD_BIT  = 2;

    // identifier word layout
    localparam int SID_LSB   = 5;
    localparam int TYPE_BIT  = 3;
    localparam int EIDH_LSB  = 0;

    // status word layout
    localparam int ST_HIT_BIT  = 15;
    localparam int ST_FIFO_BIT = 8;
    localparam int ST_FILT_LSB = 4;
    localparam int ST_BUF_LSB  = 0;

    // reset values
    localparam logic [15:0] RST_BUFPNT = 16'h0000;
    localparam logic [15:0] RST_MSKSEL = 16'h0000;
    localparam logic [15:0] RST_FEN    = 16'hffff;
    localparam logic [15:0] RST_ID     = 16'h0000;

    localparam logic [3:0] FIFO_PTR     = 4'hf;
    localparam logic [1:0] MSK_SEL_RSVD = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;
endpackage

// ===== cafs_match_if.sv
`timescale 1ns/1ps
interface cafs_match_if;
    logic [cafs_pkg::NUM_FILT-1:0][10:0] f_sid;
    logic [cafs_pkg::NUM_FILT-1:0][17:0] f_eid;
    logic [cafs_pkg::NUM_FILT-1:0]       f_id_type_enable;
    logic [cafs_pkg::NUM_FILT-1:0][1:0]  f_msk;
    logic [cafs_pkg::NUM_FILT-1:0]       f_en;
    logic [cafs_pkg::NUM_MASK-1:0][10:0] m_sid;
    logic [cafs_pkg::NUM_MASK-1:0][17:0] m_eid;
    logic [cafs_pkg::NUM_MASK-1:0]       m_id_type_mode;
    logic                                msg_ide;
    logic [10:0]                         msg_sid;
    logic [17:0]                         msg_eid;
    logic [cafs_pkg::NUM_FILT-1:0]       hit_vec;
    logic                                hit;
    logic [3:0]                          hit_idx;

    modport cfg (output f_sid, f_eid, f_id_type_enable, f_msk, f_en, m_sid, m_eid, m_id_type_mode,
                 output msg_ide, msg_sid, msg_eid, input hit_vec, hit, hit_idx);
    modport eng (input f_sid, f_eid, f_id_type_enable, f_msk, f_en, m_sid, m_eid, m_id_type_mode,
                 input msg_ide, msg_sid, msg_eid, output hit_vec, hit, hit_idx);
endinterface

// ===== cafs_match.sv
`timescale 1ns/1ps
module cafs_match (
    // filter settings in, match result out
    cafs_match_if.eng m
);
    import cafs_pkg::*;

    wire logic [NUM_FILT-1:0] hv;

    for (genvar i = 0; i < NUM_FILT; i++) begin : g_filt
        logic [1:0]  sel;
        logic [10:0] ms;
        logic [17:0] me;
        logic        id_type_mode;
        logic        sid_ok;
        logic        eid_ok;
        logic        type_ok;
        logic        rsvd;
        assign sel  = m.f_msk[i];
        assign rsvd = (sel == MSK_SEL_RSVD);
        // mask set chosen per filter; reserved code never matches
        assign ms   = rsvd ? 11'h000 : m.m_sid[sel];
        assign me   = rsvd ? 18'h00000 : m.m_eid[sel];
        assign id_type_mode = rsvd ? 1'b0 : m.m_id_type_mode[sel];
        // mask bit one compares, zero is don't care
        assign sid_ok = ((m.msg_sid ^ m.f_sid[i]) & ms) == 11'h000;
        assign eid_ok = ((m.msg_eid ^ m.f_eid[i]) & me) == 18'h00000;
        // type bit only counts when the mask asks for it
        assign type_ok = id_type_mode ? (m.msg_ide == m.f_id_type_enable[i]) : 1'b1;
        // standard frames compare sid, extended frames sid plus eid
        assign hv[i] = m.f_en[i] && !rsvd && type_ok && sid_ok
                       && (!m.msg_ide || eid_ok);
    end

    assign m.hit_vec = hv;

    always_comb begin
        m.hit     = |hv;
        m.hit_idx = 4'h0;
        // lowest numbered hit wins
        for (int k = NUM_FILT - 1; k >= 0; k--) begin
            if (hv[k]) begin
                m.hit_idx = 4'(k);
            end
        end
    end
endmodule

// ===== cafs_filter_top.sv
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - pointer all ones steers an accepted message into the receive fifo
// - pointer 0 to 14 steers into the receive buffer of that number
// - 4-bit pointer per filter, four per register, low filter in low nibble
// - pointer registers serve filters 0-3, 4-7, 8-11, 12-15 in that order
// - every compared standard identifier bit must equal the filter bit
// - 18 extended bits: two in the sid word, sixteen in the eid word
// - type mode one: filter type bit picks extended or standard frames only
// - type mode zero: filter type bit is ignored
// - mask source 00, 01, 10 pick mask 0, 1, 2; 11 is reserved
// - filters 0-7 mask sources in one register, filter 7 on top
// - sid word bits 4 and 2 ignore writes and read zero
// - mask bit one compares the identifier bit, zero makes it don't care
// - type mode zero: sid match or sid plus eid match accepts
// - only enabled filters accept; enables reset to one
// - filters 8-15 mask sources in a second register, filter 15 on top
module cafs_filter_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // received identifier from the protocol engine
    input  wire logic              msg_valid,
    input  wire logic              msg_ide,
    input  wire logic [10:0]       msg_sid,
    input  wire logic [17:0]       msg_eid,
    // steering result
    output logic                   acc_valid,
    output logic                   acc_fifo,
    output logic [3:0]             acc_buffer,
    output logic [3:0]             acc_filter,
    output logic                   rej_valid
);
    import cafs_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    localparam logic [ADDR_W-1:0] A_MSK0  = ADDR_W'(OFS_MSKSEL0);
    localparam logic [ADDR_W-1:0] A_MSK1  = ADDR_W'(OFS_MSKSEL1);
    localparam logic [ADDR_W-1:0] A_FEN   = ADDR_W'(OFS_FEN);
    localparam logic [ADDR_W-1:0] A_STAT  = ADDR_W'(OFS_STATUS);
    localparam logic [ADDR_W-1:0] A_MBASE = ADDR_W'(OFS_MASK_BASE);
    localparam logic [ADDR_W-1:0] A_MEND  = ADDR_W'(OFS_MASK_END);
    localparam logic [ADDR_W-1:0] A_FBASE = ADDR_W'(OFS_FILT_BASE);
    localparam logic [ADDR_W-1:0] A_FEND  = ADDR_W'(OFS_FILT_END);

    cafs_match_if m ();

    cafs_match cafs_match_i (
        .m (m)
    );

    // bus state
    logic              aw_hold;
    logic              w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [15:0]       w_data;
    logic [1:0]        w_strb;
    logic              next_aw_hold;
    logic              next_w_hold;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [15:0]       next_w_data;
    logic [1:0]        next_w_strb;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              do_write;
    logic [16:0]       wr_old;
    logic [16:0]       rd_val;
    logic [15:0]       wr_val;

    // configuration state
    logic [63:0]                   bp;
    logic [31:0]                   msksel;
    logic [15:0]                   fen;
    logic [NUM_FILT-1:0][10:0]     fsid;
    logic [NUM_FILT-1:0]           fexide;
    logic [NUM_FILT-1:0][17:0]     feid;
    logic [NUM_MASK-1:0][10:0]     msid;
    logic [NUM_MASK-1:0]           mmide;
    logic [NUM_MASK-1:0][17:0]     meid;
    logic [63:0]                   next_bp;
    logic [31:0]                   next_msksel;
    logic [15:0]                   next_fen;
    logic [NUM_FILT-1:0][10:0]     next_fsid;
    logic [NUM_FILT-1:0]           next_fexide;
    logic [NUM_FILT-1:0][17:0]     next_feid;
    logic [NUM_MASK-1:0][10:0]     next_msid;
    logic [NUM_MASK-1:0]           next_mmide;
    logic [NUM_MASK-1:0][17:0]     next_meid;

    // result state
    logic       last_hit;
    logic       next_last_hit;
    logic       next_acc_valid;
    logic       next_acc_fifo;
    logic [3:0] next_acc_buffer;
    logic [3:0] next_acc_filter;
    logic       next_rej_valid;
    logic [3:0] sel_bp;
    logic [15:0] status;

    assign m.f_sid   = fsid;
    assign m.f_eid   = feid;
    assign m.f_id_type_enable = fexide;
    assign m.f_msk   = msksel;
    assign m.f_en    = fen;
    assign m.m_sid   = msid;
    assign m.m_eid   = meid;
    assign m.m_id_type_mode = mmide;
    assign m.msg_ide = msg_ide;
    assign m.msg_sid = msg_sid;
    assign m.msg_eid = msg_eid;

    // pointer nibble of the winning filter
    assign sel_bp = bp[{m.hit_idx, 2'b00} +: 4];

    assign status = {last_hit, 6'h00, acc_fifo, acc_filter, acc_buffer};

    // bit 16 flags a mapped address
    function automatic logic [16:0] reg_value(input logic [ADDR_W-1:0] a);
        logic [3:0]  fi;
        logic [1:0]  mi;
        logic [16:0] r;
        fi = 4'((a - A_FBASE) >> ID_STRIDE_SH);
        mi = 2'((a - A_MBASE) >> ID_STRIDE_SH);
        r  = 17'h00000;
        if (a < A_MSK0) begin
            r = {1'b1, bp[{a[3:2], 4'h0} +: 16]};
        end else if (a == A_MSK0) begin
            r = {1'b1, msksel[15:0]};
        end else if (a == A_MSK1) begin
            r = {1'b1, msksel[31:16]};
        end else if (a == A_FEN) begin
            r = {1'b1, fen};
        end else if (a == A_STAT) begin
            r = {1'b1, status};
        end else if (a >= A_MBASE && a < A_MEND) begin
            if (a[EID_WORD_BIT]) begin
                r = {1'b1, meid[mi][15:0]};
            end else begin
                r = {1'b1, msid[mi], 1'b0, mmide[mi], 1'b0, meid[mi][17:16]};
            end
        end else if (a >= A_FBASE && a < A_FEND) begin
            if (a[EID_WORD_BIT]) begin
                r = {1'b1, feid[fi][15:0]};
            end else begin
                // unused bits 4 and 2 read zero
                r = {1'b1, fsid[fi], 1'b0, fexide[fi], 1'b0, feid[fi][17:16]};
            end
        end
        return r;
    endfunction

    // bus next state: address and data taken in either order
    always_comb begin
        do_write     = aw_hold && w_hold && !bvalid;
        next_aw_hold = aw_hold;
        next_w_hold  = w_hold;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        wr_old       = reg_value(aw_addr);
        rd_val       = reg_value(araddr);
        wr_val       = {w_strb[1] ? w_data[15:8] : wr_old[15:8],
                        w_strb[0] ? w_data[7:0] : wr_old[7:0]};
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_w_data = wdata[15:0];
            next_w_strb = wstrb[1:0];
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_old[16] ? RESP_OKAY : RESP_DECERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = {16'h0000, rd_val[15:0]};
            next_rresp  = rd_val[16] ? RESP_OKAY : RESP_DECERR;
        end
        next_awready = !next_aw_hold;
        next_wready  = !next_w_hold;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 16'h0000;
            w_strb  <= 2'h0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold  <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // configuration next state
    always_comb begin
        logic [3:0] fi;
        logic [1:0] mi;
        fi          = 4'((aw_addr - A_FBASE) >> ID_STRIDE_SH);
        mi          = 2'((aw_addr - A_MBASE) >> ID_STRIDE_SH);
        next_bp     = bp;
        next_msksel = msksel;
        next_fen    = fen;
        next_fsid   = fsid;
        next_fexide = fexide;
        next_feid   = feid;
        next_msid   = msid;
        next_mmide  = mmide;
        next_meid   = meid;
        if (do_write) begin
            if (aw_addr < A_MSK0) begin
                next_bp[{aw_addr[3:2], 4'h0} +: 16] = wr_val;
            end else if (aw_addr == A_MSK0) begin
                next_msksel[15:0] = wr_val;
            end else if (aw_addr == A_MSK1) begin
                next_msksel[31:16] = wr_val;
            end else if (aw_addr == A_FEN) begin
                next_fen = wr_val;
            end else if (aw_addr >= A_MBASE && aw_addr < A_MEND) begin
                if (aw_addr[EID_WORD_BIT]) begin
                    next_meid[mi][15:0] = wr_val;
                end else begin
                    next_msid[mi]        = wr_val[15:SID_LSB];
                    next_mmide[mi]       = wr_val[TYPE_BIT];
                    next_meid[mi][17:16] = wr_val[EIDH_LSB +: 2];
                end
            end else if (aw_addr >= A_FBASE && aw_addr < A_FEND) begin
                if (aw_addr[EID_WORD_BIT]) begin
                    next_feid[fi][15:0] = wr_val;
                end else begin
                    // bits 4 and 2 have no storage
                    next_fsid[fi]        = wr_val[15:SID_LSB];
                    next_fexide[fi]      = wr_val[TYPE_BIT];
                    next_feid[fi][17:16] = wr_val[EIDH_LSB +: 2];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp     <= {4{RST_BUFPNT}};
            msksel <= {2{RST_MSKSEL}};
            fen    <= RST_FEN;
            fsid   <= '0;
            fexide <= '0;
            feid   <= '0;
            msid   <= '0;
            mmide  <= '0;
            meid   <= '0;
        end else begin
            bp     <= next_bp;
            msksel <= next_msksel;
            fen    <= next_fen;
            fsid   <= next_fsid;
            fexide <= next_fexide;
            feid   <= next_feid;
            msid   <= next_msid;
            mmide  <= next_mmide;
            meid   <= next_meid;
        end
    end

    // steering result, one cycle after the identifier
    always_comb begin
        next_acc_valid  = msg_valid && m.hit;
        next_rej_valid  = msg_valid && !m.hit;
        next_last_hit   = last_hit;
        next_acc_fifo   = acc_fifo;
        next_acc_buffer = acc_buffer;
        next_acc_filter = acc_filter;
        if (msg_valid) begin
            next_last_hit = m.hit;
        end
        if (msg_valid && m.hit) begin
            next_acc_filter = m.hit_idx;
            next_acc_buffer = sel_bp;
            next_acc_fifo   = (sel_bp == FIFO_PTR);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_valid  <= 1'b0;
            rej_valid  <= 1'b0;
            last_hit   <= 1'b0;
            acc_fifo   <= 1'b0;
            acc_buffer <= 4'h0;
            acc_filter <= 4'h0;
        end else begin
            acc_valid  <= next_acc_valid;
            rej_valid  <= next_rej_valid;
            last_hit   <= next_last_hit;
            acc_fifo   <= next_acc_fifo;
            acc_buffer <= next_acc_buffer;
            acc_filter <= next_acc_filter;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_msg0;
        msg_valid && m.hit_vec[0] && msksel[1:0] == 2'b00;
    endsequence

    property p_fifo_steer;
        msg_valid && m.hit && sel_bp == FIFO_PTR |=> acc_valid && acc_fifo;
    endproperty
    a_fifo_steer: assert property (p_fifo_steer)
        else $error("all-ones pointer did not steer to fifo");

    property p_buf_steer;
        msg_valid && m.hit && sel_bp != FIFO_PTR
            |=> acc_valid && !acc_fifo && acc_buffer == $past(sel_bp);
    endproperty
    a_buf_steer: assert property (p_buf_steer)
        else $error("buffer number differs from pointer");

    property p_nibble_f1;
        msg_valid && m.hit && m.hit_idx == 4'h1 |=> acc_buffer == $past(bp[7:4]);
    endproperty
    a_nibble_f1: assert property (p_nibble_f1)
        else $error("filter 1 pointer not from bits 7-4");

    property p_nibble_f15;
        msg_valid && m.hit && m.hit_idx == 4'hf |=> acc_buffer == $past(bp[63:60]);
    endproperty
    a_nibble_f15: assert property (p_nibble_f15)
        else $error("filter 15 pointer not from top nibble of fourth word");

    property p_sid_cmp;
        s_msg0 |-> ((msg_sid ^ fsid[0]) & msid[0]) == 11'h000;
    endproperty
    a_sid_cmp: assert property (p_sid_cmp)
        else $error("filter 0 hit with masked sid mismatch");

    property p_eid_cmp;
        s_msg0 ##0 msg_ide |-> ((msg_eid ^ feid[0]) & meid[0]) == 18'h00000;
    endproperty
    a_eid_cmp: assert property (p_eid_cmp)
        else $error("filter 0 hit with masked eid mismatch");

    property p_type_only;
        s_msg0 ##0 mmide[0] |-> msg_ide == fexide[0];
    endproperty
    a_type_only: assert property (p_type_only)
        else $error("frame type differs from filter type bit");

    property p_rsvd_sel;
        msg_valid && msksel[1:0] == MSK_SEL_RSVD |-> !m.hit_vec[0];
    endproperty
    a_rsvd_sel: assert property (p_rsvd_sel)
        else $error("reserved mask source produced a hit");

    property p_disabled;
        msg_valid && fen == 16'h0000 |=> rej_valid && !acc_valid;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("message accepted with all filters disabled");

    property p_lowest;
        msg_valid && m.hit_vec[0] |=> acc_valid && acc_filter == 4'h0;
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("lowest matching filter did not win");

    property p_rst_vals;
        disable iff (1'b0) !aresetn |=> bp == 64'h0 && msksel == 32'h0 && fen == 16'hffff;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("wrong reset value in pointer, mask source or enable");
endmodule

// ===== cafs_engine_model.sv
`timescale 1ns/1ps
// stand-in for the protocol engine: one strobe per identifier, lines scrambled when idle
module cafs_engine_model (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // request from the bench
    input  wire logic        send,
    input  wire logic        ide,
    input  wire logic [28:0] id,
    // received identifier
    output logic             msg_valid,
    output logic             msg_ide,
    output logic [10:0]      msg_sid,
    output logic [17:0]      msg_eid
);
    initial {msg_valid, msg_ide, msg_sid, msg_eid} = '0;
    always @(posedge aclk) begin
        msg_valid <= send && aresetn;
        if (send) begin
            {msg_ide, msg_sid, msg_eid} <= {ide, id};
        end else begin
            {msg_ide, msg_sid, msg_eid} <= ~{msg_ide, msg_sid, msg_eid};
        end
    end
endmodule

// ===== can_acceptance_filter_steering_tb.sv
`timescale 1ns/1ps
module can_acceptance_filter_steering_tb;
    import cafs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, send = 1'b0, ide = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'h3, acc_buffer, acc_filter;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, msg_valid, msg_ide;
    logic        acc_valid, acc_fifo, rej_valid;
    logic [1:0]  bresp, rresp;
    logic [10:0] msg_sid;
    logic [17:0] msg_eid;
    logic [28:0] id = '0;
    int          num_errors = 0;
    int          checked = 0;

    always #10 aclk = ~aclk;

    cafs_filter_top #(.ADDR_W(8)) cafs_filter_top_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .msg_valid(msg_valid), .msg_ide(msg_ide),
        .msg_sid(msg_sid), .msg_eid(msg_eid), .acc_valid(acc_valid), .acc_fifo(acc_fifo),
        .acc_buffer(acc_buffer), .acc_filter(acc_filter), .rej_valid(rej_valid));
    cafs_engine_model cafs_engine_model_i (.aclk(aclk), .aresetn(aresetn), .send(send),
        .ide(ide), .id(id), .msg_valid(msg_valid), .msg_ide(msg_ide), .msg_sid(msg_sid),
        .msg_eid(msg_eid));

    task automatic end_of_test;
        $display("comparisons %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            chk("write answer", 32'h1, 32'h0);
            end_of_test();
        end
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            chk("read answer", 32'h1, 32'h0);
            end_of_test();
        end
        chk("rdata", rdata, {16'h0000, d});
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    // one identifier through the engine model, then the one-cycle verdict
    task automatic msg(input logic x, input logic [10:0] s, input logic [17:0] e,
                       input logic ok, input logic [3:0] f, input logic [3:0] b);
        send <= 1'b1;
        ide <= x;
        id <= {s, e};
        @(posedge aclk);
        send <= 1'b0;
        @(posedge aclk);
        #1;
        if (ok) chk("accept", {acc_valid, rej_valid, acc_fifo, acc_filter, acc_buffer},
                    {2'b10, b == 4'hf, f, b});
        else chk("reject", {acc_valid, rej_valid}, 32'h1);
        @(posedge aclk);
    endtask

    task automatic t_reset;
        rd(OFS_BUFPNT0 + 8'h0c, 16'h0000);
        rd(OFS_MSKSEL1, 16'h0000);
        rd(OFS_FEN, 16'hffff);
        msg(1'b1, 11'h555, 18'h2aaaa, 1'b1, 4'h0, 4'h0);
        wr(8'hb8, 16'hffff);
        rd(8'hb8, 16'hffeb);
        wstrb <= 4'h1;
        wr(8'hb8, 16'h0000);
        wstrb <= 4'h3;
        rd(8'hb8, 16'hff00);
        wr(8'hfc, 16'h1234, RESP_DECERR);
        rd(8'hfc, 16'h0000, RESP_DECERR);
    endtask

    task automatic t_steer;
        int i;
        wr(OFS_BUFPNT0, 16'hcdef);
        wr(OFS_BUFPNT0 + 8'h04, 16'h89ab);
        wr(OFS_BUFPNT0 + 8'h08, 16'h4567);
        wr(OFS_BUFPNT0 + 8'h0c, 16'h0123);
        for (i = 0; i < 16; i++) begin
            wr(OFS_FEN, 16'h0001 << i);
            msg(1'b0, 11'(i), 18'h0, 1'b1, 4'(i), 4'(15 - i));
        end
        wr(OFS_FEN, 16'h0000);
        msg(1'b0, 11'h0, 18'h0, 1'b0, 4'h0, 4'h0);
        wr(OFS_FEN, 16'h8006);
        msg(1'b0, 11'h0, 18'h0, 1'b1, 4'h1, 4'he);
        rd(OFS_STATUS, 16'h801e);
    endtask

    task automatic t_match;
        wr(OFS_FEN, 16'h0001);
        wr(OFS_MASK_BASE, 16'hffe3);
        wr(OFS_MASK_BASE + 8'h04, 16'hffff);
        wr(OFS_FILT_BASE, {11'h123, 5'h02});
        wr(OFS_FILT_BASE + 8'h04, 16'h4567);
        msg(1'b0, 11'h123, 18'h0, 1'b1, 4'h0, 4'hf);
        msg(1'b0, 11'h122, 18'h0, 1'b0, 4'h0, 4'hf);
        msg(1'b1, 11'h123, 18'h24567, 1'b1, 4'h0, 4'hf);
        msg(1'b1, 11'h123, 18'h14567, 1'b0, 4'h0, 4'hf);
        msg(1'b1, 11'h123, 18'h24566, 1'b0, 4'h0, 4'hf);
        wr(OFS_MASK_BASE + 8'h04, 16'hfffe);
        msg(1'b1, 11'h123, 18'h24566, 1'b1, 4'h0, 4'hf);
    endtask

    task automatic t_type;
        wr(OFS_MASK_BASE, 16'hffeb);
        msg(1'b1, 11'h123, 18'h24567, 1'b0, 4'h0, 4'hf);
        msg(1'b0, 11'h123, 18'h0, 1'b1, 4'h0, 4'hf);
        wr(OFS_FILT_BASE, {11'h123, 5'h0a});
        msg(1'b1, 11'h123, 18'h24567, 1'b1, 4'h0, 4'hf);
        msg(1'b0, 11'h123, 18'h0, 1'b0, 4'h0, 4'hf);
    endtask

    task automatic t_masksel;
        int c;
        wr(OFS_FEN, 16'h0100);
        wr(OFS_MASK_BASE + 8'h08, 16'hffe0);
        for (c = 0; c < 4; c++) begin
            wr(OFS_MSKSEL1, 16'(c));
            msg(1'b0, 11'h7ff, 18'h0, c == 2, 4'h8, 4'h7);
        end
        wr(OFS_FEN, 16'h0080);
        wr(OFS_MSKSEL0, 16'h8000);
        msg(1'b0, 11'h7ff, 18'h0, 1'b1, 4'h7, 4'h8);
        wr(OFS_MSKSEL0, 16'h0002);
        msg(1'b0, 11'h7ff, 18'h0, 1'b0, 4'h7, 4'h8);
        wr(OFS_FEN, 16'h0001);
        wr(OFS_MSKSEL0, 16'h0003);
        msg(1'b1, 11'h123, 18'h24567, 1'b0, 4'h0, 4'hf);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_steer();
        t_match();
        t_type();
        t_masksel();
        end_of_test();
    end
endmodule
